// ### rtl/vpaa_pkg.sv
// Purpose: constants and carriers for the virtual phy advertisement register bank
// Assumes: 10 MHz i_mclk, 32-bit mapped and 16-bit serial-management access
// Notes:   fixed bit values are folded into the writable mask
//
// Contract
// - bits 31-16 read as zero padding; serial management view is 16 bits wide
// - bit 15 next page is read-only zero
// - bit 13 remote fault is read-only zero
// - bit 11 asymmetric pause is read/write, resets to zero
// - bit 10 pause is read/write, defaults to inverse of latched flow strap
// - bit 9 100BASE-T4 is read-only zero
// - bits 8 and 7 100BASE-X full/half are read/write, default one
// - bits 6 and 5 10BASE-T full/half are read/write, default one
// - bits 4:0 selector read/write, default 00001b; software writes only that (the register stores any selector value written)
// - loader overwrites whole register after reset release or reload command
// - partner ability register at 1D4h is read-only emulated values
`default_nettype none

package vpaa_pkg;

   // ------------------------------------------------------------
   // map
   // ------------------------------------------------------------
   localparam logic [8:0]  ADV_OFFSET     = 9'h1D0;
   localparam logic [8:0]  PARTNER_OFFSET = 9'h1D4;
   localparam logic [4:0]  ADV_INDEX      = 5'h04;
   localparam logic [4:0]  PARTNER_INDEX  = 5'h05;

   // ------------------------------------------------------------
   // fields
   // ------------------------------------------------------------
   localparam int          ASYM_POS       = 11;
   localparam int          PAUSE_POS      = 10;
   localparam logic [15:0] ADV_WR_MASK    = 16'h0DFF;
   localparam logic [15:0] ADV_RESET      = 16'h01E1;
   localparam logic [1:0]  STRAP_SETTLE   = 2'h3;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed
   {
      logic        rd;
      logic        wr;
      logic [8:0]  addr;
      logic [31:0] wdata;
   } vpaa_mm_req_s;

   typedef struct packed
   {
      logic        rd;
      logic        wr;
      logic [4:0]  idx;
      logic [15:0] wdata;
   } vpaa_mii_req_s;

endpackage : vpaa_pkg

`default_nettype wire

// ### rtl/vpaa_advert_regs.sv
// Purpose: advertisement and partner ability registers of the virtual phy
// Assumes: loader supplies reload words; partner value comes from the emulator
// Notes:   read data registered, one cycle after the read strobe
`default_nettype none

module vpaa_advert_regs
   import vpaa_pkg::*;
(
   input  wire logic          i_mclk,
   input  wire logic          i_rstn,
   input  wire vpaa_mm_req_s  i_mm_req,
   output logic [31:0]        o_mm_rdata,
   input  wire vpaa_mii_req_s i_mii_req,
   output logic [15:0]        o_mii_rdata,
   input  wire logic          i_reload,
   output logic               o_load_req,
   input  wire logic          i_load_valid,
   input  wire logic [15:0]   i_load_data,
   input  wire logic          i_flow_ctrl_manual_strap,
   input  wire logic [15:0]   i_partner_ability,
   output logic [15:0]        o_advert
);

   // ------------------------------------------------------------
   // strap capture
   // ------------------------------------------------------------
   logic       strap_s1_ff, strap_s2_ff, strap_s3_ff;
   logic [1:0] settle_ff,   nxt_settle;
   logic       captured_ff, nxt_captured;
   logic       capture;

   // a strap is only caught once the synchroniser has filled after release
   always_comb
   begin
      nxt_settle   = settle_ff;
      nxt_captured = captured_ff;
      capture      = 1'b0;
      if (settle_ff != STRAP_SETTLE)
      begin
         nxt_settle = settle_ff + 2'h1;
      end
      else if (!captured_ff && (strap_s2_ff == strap_s3_ff))
      begin
         capture      = 1'b1;
         nxt_captured = 1'b1;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         strap_s1_ff <= 1'b0;
         strap_s2_ff <= 1'b0;
         strap_s3_ff <= 1'b0;
         settle_ff   <= 2'h0;
         captured_ff <= 1'b0;
      end
      else
      begin
         strap_s1_ff <= i_flow_ctrl_manual_strap;
         strap_s2_ff <= strap_s1_ff;
         strap_s3_ff <= strap_s2_ff;
         settle_ff   <= nxt_settle;
         captured_ff <= nxt_captured;
      end
   end

   // ------------------------------------------------------------
   // loader request
   // ------------------------------------------------------------
   logic boot_ff, nxt_boot;
   logic load_req_ff, nxt_load_req;

   always_comb
   begin
      nxt_boot     = 1'b1;
      nxt_load_req = !boot_ff || i_reload;
   end

   always_ff @(posedge i_mclk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         boot_ff     <= 1'b0;
         load_req_ff <= 1'b0;
      end
      else
      begin
         boot_ff     <= nxt_boot;
         load_req_ff <= nxt_load_req;
      end
   end

   assign o_load_req = load_req_ff;

   // ------------------------------------------------------------
   // advertisement register
   // ------------------------------------------------------------
   logic [15:0] adv_ff, nxt_adv;
   logic        mm_adv_wr, mii_adv_wr;

   assign mm_adv_wr  = i_mm_req.wr && (i_mm_req.addr == ADV_OFFSET);
   assign mii_adv_wr = i_mii_req.wr && (i_mii_req.idx == ADV_INDEX);

   // loader beats software; later source wins within a cycle
   always_comb
   begin
      nxt_adv = adv_ff;
      if (capture)
      begin
         nxt_adv[PAUSE_POS] = !strap_s3_ff;
      end
      if (mii_adv_wr)
      begin
         nxt_adv = i_mii_req.wdata & ADV_WR_MASK;
      end
      if (mm_adv_wr)
      begin
         nxt_adv = i_mm_req.wdata[15:0] & ADV_WR_MASK;
      end
      if (i_load_valid)
      begin
         nxt_adv = i_load_data & ADV_WR_MASK;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         adv_ff <= ADV_RESET;
      end
      else
      begin
         adv_ff <= nxt_adv;
      end
   end

   assign o_advert = adv_ff;

   // ------------------------------------------------------------
   // read back
   // ------------------------------------------------------------
   logic [31:0] mm_rdata_ff,  nxt_mm_rdata;
   logic [15:0] mii_rdata_ff, nxt_mii_rdata;

   // unmapped reads return zero; upper half is padding
   always_comb
   begin
      nxt_mm_rdata  = mm_rdata_ff;
      nxt_mii_rdata = mii_rdata_ff;
      if (i_mm_req.rd)
      begin
         unique case (i_mm_req.addr)
            ADV_OFFSET:     nxt_mm_rdata = {16'h0000, adv_ff};
            PARTNER_OFFSET: nxt_mm_rdata = {16'h0000, i_partner_ability};
            default:        nxt_mm_rdata = 32'h0000_0000;
         endcase
      end
      if (i_mii_req.rd)
      begin
         unique case (i_mii_req.idx)
            ADV_INDEX:     nxt_mii_rdata = adv_ff;
            PARTNER_INDEX: nxt_mii_rdata = i_partner_ability;
            default:       nxt_mii_rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         mm_rdata_ff  <= 32'h0000_0000;
         mii_rdata_ff <= 16'h0000;
      end
      else
      begin
         mm_rdata_ff  <= nxt_mm_rdata;
         mii_rdata_ff <= nxt_mii_rdata;
      end
   end

   assign o_mm_rdata  = mm_rdata_ff;
   assign o_mii_rdata = mii_rdata_ff;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   AST_PAD_ZERO: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      o_mm_rdata[31:16] == 16'h0000)
      else $error("padding bits not zero");

   AST_MII_VIEW: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (i_mii_req.rd && i_mii_req.idx == ADV_INDEX) |=> o_mii_rdata == $past(adv_ff))
      else $error("serial view differs from register");

   AST_NP_ZERO: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (i_mm_req.rd && i_mm_req.addr == ADV_OFFSET) |=> !o_mm_rdata[15])
      else $error("next page reads one");

   AST_RF_ZERO: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (i_mii_req.rd && i_mii_req.idx == ADV_INDEX) |=> !o_mii_rdata[13])
      else $error("remote fault reads one");

   AST_ASYM_WR: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (mm_adv_wr && !i_load_valid) |=> adv_ff[ASYM_POS] == $past(i_mm_req.wdata[ASYM_POS]))
      else $error("asymmetric pause write lost");

   AST_PAUSE_DEF: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (capture && !i_load_valid && !mm_adv_wr && !mii_adv_wr)
      |=> adv_ff[PAUSE_POS] == !$past(strap_s3_ff))
      else $error("pause default does not follow strap");

   AST_T4_ZERO: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      $rose(i_load_valid) |=> !adv_ff[9])
      else $error("100BASE-T4 bit set");

   AST_ABIL_WR: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (mii_adv_wr && !mm_adv_wr && !i_load_valid)
      |=> adv_ff[8:5] == $past(i_mii_req.wdata[8:5]))
      else $error("ability bits write lost");

   AST_SEL_WR: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (mm_adv_wr && !i_load_valid) |=> adv_ff[4:0] == $past(i_mm_req.wdata[4:0]))
      else $error("selector write lost");

   AST_LOAD: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      i_load_valid |=> adv_ff == ($past(i_load_data) & ADV_WR_MASK))
      else $error("loader value not taken");

   AST_LOAD_REQ: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      i_reload |=> o_load_req)
      else $error("reload not requested");

   AST_PARTNER_RO: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (i_mm_req.rd && i_mm_req.addr == PARTNER_OFFSET)
      |=> o_mm_rdata[15:0] == $past(i_partner_ability))
      else $error("partner read wrong");

   AST_RO_KEEP: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (adv_ff & ~ADV_WR_MASK) == 16'h0000)
      else $error("read-only bit changed");

endmodule : vpaa_advert_regs

`default_nettype wire

// ### tb/vpaa_loader_model.sv
// Purpose: behavioural configuration loader answering load requests
// Assumes: one request outstanding at a time; delay set by the bench
// Notes:   data is inverted once valid drops, never left at the last word
`default_nettype none
module vpaa_loader_model
(
   input  wire logic        i_mclk,
   input  wire logic        i_load_req,
   input  wire logic [7:0]  i_delay,
   input  wire logic [15:0] i_word,
   output logic             o_load_valid,
   output logic [15:0]      o_load_data
);
   timeunit 1ns;
   timeprecision 1ns;
   // one process owns both outputs, so there is a single driver each
   initial
   begin
      o_load_valid = 1'b0;
      o_load_data  = 16'h0000;
      forever
      begin
         @(posedge i_mclk);
         if (i_load_req)
         begin
            repeat (i_delay) @(posedge i_mclk);
            #1 o_load_valid = 1'b1;
            o_load_data = i_word;
            @(posedge i_mclk);
            #1 o_load_valid = 1'b0;
            o_load_data = ~i_word;
         end
      end
   end
endmodule : vpaa_loader_model
`default_nettype wire

// ### tb/virtual_phy_autoneg_advert_test.sv
// Purpose: self-checking bench for the advertisement register bank
// Assumes: 100 ns clock, inputs driven 1 ns after the rising edge
// Notes:   reference value kept in the bench and masked by hand
`default_nettype none
module virtual_phy_autoneg_advert_test
   import vpaa_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   logic          i_mclk = 1'b0;
   logic          i_rstn = 1'b0;
   vpaa_mm_req_s  mm = '0;
   vpaa_mii_req_s mi = '0;
   logic          reload = 1'b0;
   logic          strap = 1'b0;
   logic          ld_req;
   logic          ld_v;
   logic [15:0]   ld_d;
   logic [15:0]   ld_w = 16'h0000;
   logic [15:0]   partner = 16'h0000;
   logic [15:0]   adv;
   logic [15:0]   exp_adv;
   logic [31:0]   mrd;
   logic [15:0]   ird;
   logic [7:0]    dly = 8'h14;
   logic [31:0]   lfsr = 32'h28ED;
   int            n_errors = 0;
   int            checked = 0;

   vpaa_advert_regs vpaa_advert_regs_i (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_mm_req(mm),
      .o_mm_rdata(mrd), .i_mii_req(mi), .o_mii_rdata(ird), .i_reload(reload),
      .o_load_req(ld_req), .i_load_valid(ld_v), .i_load_data(ld_d),
      .i_flow_ctrl_manual_strap(strap), .i_partner_ability(partner), .o_advert(adv));
   vpaa_loader_model vpaa_loader_model_i (.i_mclk(i_mclk), .i_load_req(ld_req),
      .i_delay(dly), .i_word(ld_w), .o_load_valid(ld_v), .o_load_data(ld_d));

   always #50 i_mclk = ~i_mclk;

   function automatic void rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
   endfunction : rnd

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // -----------------------------------------
   // one strobe on either port, then compare
   // -----------------------------------------
   task automatic acc(input logic ii, input logic wr, input logic [8:0] a,
                      input logic [15:0] d);
      @(posedge i_mclk);
      #1 mm.addr = a;
      mm.wdata = {16'hFFFF, d};
      mi.wdata = d;
      mi.idx = (a == ADV_OFFSET) ? ADV_INDEX : (a == PARTNER_OFFSET) ? PARTNER_INDEX : 5'h1F;
      {mm.rd, mm.wr, mi.rd, mi.wr} = ii ? {2'b00, ~wr, wr} : {~wr, wr, 2'b00};
      @(posedge i_mclk);
      #1 {mm.rd, mm.wr, mi.rd, mi.wr} = 4'h0;
      if (wr && a == ADV_OFFSET)
         exp_adv = d & 16'h0DFF;
      if (wr)
         check(adv, exp_adv);
      else if (ii)
         check(ird, (a == ADV_OFFSET) ? exp_adv : (a == PARTNER_OFFSET) ? partner : 16'h0);
      else
         check(mrd, (a == ADV_OFFSET) ? exp_adv : (a == PARTNER_OFFSET) ? partner : 16'h0);
   endtask : acc

   // valid is looked at on the edge itself, where the design takes it
   task automatic wait_load();
      int k;
      k = 0;
      while (k < 40 && ld_v !== 1'b1)
      begin
         @(posedge i_mclk);
         k++;
      end
      check(ld_v, 1'b1);
      #1 exp_adv = ld_w & 16'h0DFF;
      check(adv, exp_adv);
   endtask : wait_load

   task automatic rst_run(input logic s);
      i_rstn = 1'b0;
      strap = s;
      dly = 8'h14;
      rnd();
      ld_w = lfsr[15:0];
      // flops only settle on a clock edge when reset starts low at time zero
      repeat (12) @(posedge i_mclk);
      #1 check(adv, 16'h01E1);
      i_rstn = 1'b1;
      repeat (8) @(posedge i_mclk);
      #1 exp_adv = {5'h00, ~s, 10'h1E1};
      check(adv, exp_adv);
      wait_load();
   endtask : rst_run

   task automatic complete_run();
      $display("errors=%0d checks=%0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : complete_run

   initial
   begin
      rst_run(lfsr[0]);
      repeat (24)
      begin
         rnd();
         partner = lfsr[31:16];
         acc(lfsr[0], 1'b1, ADV_OFFSET, {lfsr[31:21], 5'h01});
         acc(lfsr[1], 1'b0, ADV_OFFSET, 16'h0000);
         acc(lfsr[2], 1'b1, PARTNER_OFFSET, ~lfsr[15:0]);
         acc(lfsr[3], 1'b0, PARTNER_OFFSET, 16'h0000);
         acc(lfsr[4], 1'b0, 9'h1D8, 16'h0000);
      end
      // short loader delay: reload answered promptly
      dly = 8'h01;
      rnd();
      ld_w = lfsr[15:0];
      @(posedge i_mclk);
      #1 reload = 1'b1;
      @(posedge i_mclk);
      #1 reload = 1'b0;
      wait_load();
      acc(1'b1, 1'b0, ADV_OFFSET, 16'h0000);
      @(posedge i_mclk);
      #1 rst_run(~strap);
      complete_run();
   end

   initial
   begin
      #400000;
      n_errors++;
      complete_run();
   end
endmodule : virtual_phy_autoneg_advert_test
`default_nettype wire
